/* common/ufc_map.svh */
// Behaviour
// - rx reset bit, honoured with fifo enable set, clears rx pointers and count only.
// - tx reset bit, honoured with fifo enable set, clears tx pointers and count only.
// - both fifo reset bits clear themselves once the reset is done.
// - dma mode bit picks tx/rx ready pin behaviour; zero is normal, one is dma while fifo enable is set, normal otherwise.
// - tx interrupt when count falls below trigger, or on empty if never filled past it.
// - tx trigger select writable only with enhanced feature enable set; host sets it first.
// - rx interrupt when rx character count crosses the rx trigger level.
// - rx and tx always share one trigger table; the last selection applies to both.
// - table a: tx trigger one; rx codes give 1, 4, 8, 14.
// - table b: tx 16, 8, 24, 30; rx 8, 16, 24, 28.
// - table c: tx 8, 16, 32, 56; rx 8, 16, 56, 60.
// - table d ignores codes; programmable register sets rx level when direction zero, tx when one.
// - after reset both trigger selects are zero, trigger level one each way.
// - fifo control writes with enable bit zero ignore every other bit.
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH

`define UFC_ADDR_CTL      3'h2
`define UFC_ADDR_FEAT     3'h3
`define UFC_ADDR_ENH      3'h4
`define UFC_ADDR_LVL      3'h5
`define UFC_ADDR_RXCNT    3'h6
`define UFC_ADDR_SHADOW   3'h7

`define UFC_CTL_EN        0
`define UFC_CTL_RXRST     1
`define UFC_CTL_TXRST     2
`define UFC_CTL_DMA       3
`define UFC_CTL_TXSEL_LO  4
`define UFC_CTL_TXSEL_HI  5
`define UFC_CTL_RXSEL_LO  6
`define UFC_CTL_RXSEL_HI  7
`define UFC_FEAT_TBL_LO   4
`define UFC_FEAT_TBL_HI   5
`define UFC_FEAT_DIR      7
`define UFC_ENH_ON        4

`define UFC_RST_BYTE      8'h00
`define UFC_RST_SEL       2'h0
`define UFC_RST_PROG      8'h01
`define UFC_FIFO_DEPTH    7'h40

`define UFC_TA_TX         8'h01
`define UFC_TA_RX0        8'h01
`define UFC_TA_RX1        8'h04
`define UFC_TA_RX2        8'h08
`define UFC_TA_RX3        8'h0e
`define UFC_TB_TX0        8'h10
`define UFC_TB_TX1        8'h08
`define UFC_TB_TX2        8'h18
`define UFC_TB_TX3        8'h1e
`define UFC_TB_RX0        8'h08
`define UFC_TB_RX1        8'h10
`define UFC_TB_RX2        8'h18
`define UFC_TB_RX3        8'h1c
`define UFC_TC_TX0        8'h08
`define UFC_TC_TX1        8'h10
`define UFC_TC_TX2        8'h20
`define UFC_TC_TX3        8'h38
`define UFC_TC_RX0        8'h08
`define UFC_TC_RX1        8'h10
`define UFC_TC_RX2        8'h38
`define UFC_TC_RX3        8'h3c

`endif

/* common/ufc_pkg.sv */
package ufc_pkg;
	typedef logic [5:0] ufc_ptr_t;
	typedef logic [6:0] ufc_cnt_t;
	typedef logic [7:0] ufc_lvl_t;
	typedef logic [1:0] ufc_code_t;
	typedef enum logic [1:0] {
		tbl_a = 2'h0,
		tbl_b = 2'h1,
		tbl_c = 2'h2,
		tbl_d = 2'h3
	} ufc_tbl_e;
endpackage : ufc_pkg

/* common/ufc_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface ufc_lvl_if;
	logic              push;
	logic              pop;
	logic              flush;
	ufc_pkg::ufc_ptr_t wr_ptr;
	ufc_pkg::ufc_ptr_t rd_ptr;
	ufc_pkg::ufc_cnt_t count;
	logic              full;
	modport cnt  (input push, pop, flush, output wr_ptr, rd_ptr, count, full);
	modport ctrl (output push, pop, flush, input wr_ptr, rd_ptr, count, full);
endinterface : ufc_lvl_if

interface ufc_trig_if;
	ufc_pkg::ufc_tbl_e  tbl;
	ufc_pkg::ufc_code_t rx_code;
	ufc_pkg::ufc_code_t tx_code;
	ufc_pkg::ufc_lvl_t  rx_prog;
	ufc_pkg::ufc_lvl_t  tx_prog;
	ufc_pkg::ufc_lvl_t  rx_lvl;
	ufc_pkg::ufc_lvl_t  tx_lvl;
	modport look (input tbl, rx_code, tx_code, rx_prog, tx_prog, output rx_lvl, tx_lvl);
	modport ctrl (output tbl, rx_code, tx_code, rx_prog, tx_prog, input rx_lvl, tx_lvl);
endinterface : ufc_trig_if

`default_nettype wire

/* core/ufc_trig_lookup.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ufc_map.svh"

module ufc_trig_lookup (
	ufc_trig_if.look t
);
	always_comb begin
		t.rx_lvl = `UFC_TA_RX0;
		t.tx_lvl = `UFC_TA_TX;
		unique case (t.tbl)
			ufc_pkg::tbl_a: begin
				t.tx_lvl = `UFC_TA_TX;
				unique case (t.rx_code)
					2'h0: t.rx_lvl = `UFC_TA_RX0;
					2'h1: t.rx_lvl = `UFC_TA_RX1;
					2'h2: t.rx_lvl = `UFC_TA_RX2;
					2'h3: t.rx_lvl = `UFC_TA_RX3;
				endcase
			end
			ufc_pkg::tbl_b: begin
				unique case (t.tx_code)
					2'h0: t.tx_lvl = `UFC_TB_TX0;
					2'h1: t.tx_lvl = `UFC_TB_TX1;
					2'h2: t.tx_lvl = `UFC_TB_TX2;
					2'h3: t.tx_lvl = `UFC_TB_TX3;
				endcase
				unique case (t.rx_code)
					2'h0: t.rx_lvl = `UFC_TB_RX0;
					2'h1: t.rx_lvl = `UFC_TB_RX1;
					2'h2: t.rx_lvl = `UFC_TB_RX2;
					2'h3: t.rx_lvl = `UFC_TB_RX3;
				endcase
			end
			ufc_pkg::tbl_c: begin
				unique case (t.tx_code)
					2'h0: t.tx_lvl = `UFC_TC_TX0;
					2'h1: t.tx_lvl = `UFC_TC_TX1;
					2'h2: t.tx_lvl = `UFC_TC_TX2;
					2'h3: t.tx_lvl = `UFC_TC_TX3;
				endcase
				unique case (t.rx_code)
					2'h0: t.rx_lvl = `UFC_TC_RX0;
					2'h1: t.rx_lvl = `UFC_TC_RX1;
					2'h2: t.rx_lvl = `UFC_TC_RX2;
					2'h3: t.rx_lvl = `UFC_TC_RX3;
				endcase
			end
			ufc_pkg::tbl_d: begin
				t.rx_lvl = t.rx_prog;
				t.tx_lvl = t.tx_prog;
			end
		endcase
	end
endmodule : ufc_trig_lookup

`default_nettype wire

/* core/ufc_fifo_level.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ufc_map.svh"

module ufc_fifo_level (
	input wire logic sys_clk,
	input wire logic srst,
	ufc_lvl_if.cnt   l
);
	ufc_pkg::ufc_ptr_t wr_r, wr_nxt, rd_r, rd_nxt;
	ufc_pkg::ufc_cnt_t cnt_r, cnt_nxt;
	logic              push_ok, pop_ok;

	always_comb begin
		push_ok = l.push && (cnt_r != `UFC_FIFO_DEPTH);
		pop_ok  = l.pop && (cnt_r != 7'h00);
		wr_nxt  = wr_r + {5'h00, push_ok};
		rd_nxt  = rd_r + {5'h00, pop_ok};
		cnt_nxt = cnt_r + {6'h00, push_ok} - {6'h00, pop_ok};
		// flush wins over a push or pop in the same cycle; data storage is untouched
		if (l.flush) begin
			wr_nxt  = 6'h00;
			rd_nxt  = 6'h00;
			cnt_nxt = 7'h00;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_r  <= 6'h00;
			rd_r  <= 6'h00;
			cnt_r <= 7'h00;
		end else begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign l.wr_ptr = wr_r;
	assign l.rd_ptr = rd_r;
	assign l.count  = cnt_r;
	assign l.full   = (cnt_r == `UFC_FIFO_DEPTH);
endmodule : ufc_fifo_level

`default_nettype wire

/* core/ufc_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ufc_map.svh"

module ufc_top (
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic [2:0] bus_addr,
	input  wire logic [7:0] bus_wdata,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	output logic      [7:0] bus_rdata,
	input  wire logic       rx_push,
	input  wire logic       rx_pop,
	input  wire logic       tx_push,
	input  wire logic       tx_pop,
	output logic      [6:0] rx_count,
	output logic      [6:0] tx_count,
	output logic            fifo_en,
	output logic            dma_mode,
	output logic            rx_int,
	output logic            tx_int,
	output logic            rx_ready_pin_n,
	output logic            tx_ready_pin_n
);
	////////////////////////////////////////////////////////////////////////////
	// register decode

	logic wr_ctl;
	logic wr_feat;
	logic wr_enh;
	logic wr_lvl;
	logic rd_status;
	logic wr_en_bit;

	// a write and a read in one cycle both act; the host is expected to issue one at a time
	assign wr_ctl    = bus_wr && (bus_addr == `UFC_ADDR_CTL);
	assign wr_feat   = bus_wr && (bus_addr == `UFC_ADDR_FEAT);
	assign wr_enh    = bus_wr && (bus_addr == `UFC_ADDR_ENH);
	assign wr_lvl    = bus_wr && (bus_addr == `UFC_ADDR_LVL);
	assign rd_status = bus_rd && (bus_addr == `UFC_ADDR_CTL);
	assign wr_en_bit = bus_wdata[`UFC_CTL_EN];

	////////////////////////////////////////////////////////////////////////////
	// control registers

	logic                 en_r;
	logic                 en_nxt;
	logic                 dma_r;
	logic                 dma_nxt;
	ufc_pkg::ufc_code_t   txsel_r;
	ufc_pkg::ufc_code_t   txsel_nxt;
	ufc_pkg::ufc_code_t   rxsel_r;
	ufc_pkg::ufc_code_t   rxsel_nxt;
	logic           [7:0] feat_r;
	logic           [7:0] feat_nxt;
	logic           [7:0] enh_r;
	logic           [7:0] enh_nxt;
	// programmable levels reset to one so table d starts out like table a
	ufc_pkg::ufc_lvl_t    rxprog_r;
	ufc_pkg::ufc_lvl_t    rxprog_nxt;
	ufc_pkg::ufc_lvl_t    txprog_r;
	ufc_pkg::ufc_lvl_t    txprog_nxt;

	always_comb begin
		en_nxt     = en_r;
		dma_nxt    = dma_r;
		txsel_nxt  = txsel_r;
		rxsel_nxt  = rxsel_r;
		feat_nxt   = feat_r;
		enh_nxt    = enh_r;
		rxprog_nxt = rxprog_r;
		txprog_nxt = txprog_r;
		if (wr_ctl) begin
			en_nxt = wr_en_bit;
			if (wr_en_bit) begin
				dma_nxt   = bus_wdata[`UFC_CTL_DMA];
				rxsel_nxt = bus_wdata[`UFC_CTL_RXSEL_HI:`UFC_CTL_RXSEL_LO];
				// a locked select write is dropped, not held for later
				// enhanced gate
				if (enh_r[`UFC_ENH_ON]) begin
					txsel_nxt = bus_wdata[`UFC_CTL_TXSEL_HI:`UFC_CTL_TXSEL_LO];
				end
			end
		end
		if (wr_feat) begin
			feat_nxt = bus_wdata;
		end
		if (wr_enh) begin
			enh_nxt = bus_wdata;
		end
		if (wr_lvl) begin
			if (feat_r[`UFC_FEAT_DIR]) begin
				txprog_nxt = bus_wdata;
			end else begin
				rxprog_nxt = bus_wdata;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			en_r     <= 1'b0;
			dma_r    <= 1'b0;
			txsel_r  <= `UFC_RST_SEL;
			rxsel_r  <= `UFC_RST_SEL;
			feat_r   <= `UFC_RST_BYTE;
			enh_r    <= `UFC_RST_BYTE;
			rxprog_r <= `UFC_RST_PROG;
			txprog_r <= `UFC_RST_PROG;
		end else begin
			en_r     <= en_nxt;
			dma_r    <= dma_nxt;
			txsel_r  <= txsel_nxt;
			rxsel_r  <= rxsel_nxt;
			feat_r   <= feat_nxt;
			enh_r    <= enh_nxt;
			rxprog_r <= rxprog_nxt;
			txprog_r <= txprog_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fifo level counters and trigger lookup

	ufc_lvl_if  rx_l ();
	ufc_lvl_if  tx_l ();
	ufc_trig_if trig ();

	assign rx_l.flush = wr_ctl && wr_en_bit && bus_wdata[`UFC_CTL_RXRST];
	assign tx_l.flush = wr_ctl && wr_en_bit && bus_wdata[`UFC_CTL_TXRST];
	assign rx_l.push  = rx_push;
	assign rx_l.pop   = rx_pop;
	assign tx_l.push  = tx_push;
	assign tx_l.pop   = tx_pop;

	ufc_fifo_level u_rx_level (
		.sys_clk (sys_clk),
		.srst    (srst),
		.l       (rx_l.cnt)
	);

	ufc_fifo_level u_tx_level (
		.sys_clk (sys_clk),
		.srst    (srst),
		.l       (tx_l.cnt)
	);

	assign trig.tbl     = ufc_pkg::ufc_tbl_e'(feat_r[`UFC_FEAT_TBL_HI:`UFC_FEAT_TBL_LO]);
	assign trig.rx_code = rxsel_r;
	assign trig.tx_code = txsel_r;
	assign trig.rx_prog = rxprog_r;
	assign trig.tx_prog = txprog_r;

	ufc_trig_lookup u_lookup (
		.t (trig.look)
	);

	////////////////////////////////////////////////////////////////////////////
	// interrupt conditions

	logic tx_below, tx_below_r, tx_below_nxt;
	logic tx_over_r, tx_over_nxt;
	logic tx_empty, tx_empty_r, tx_empty_nxt;
	logic tx_int_r, tx_int_nxt;
	logic rx_int_r, rx_int_nxt;
	logic tx_set;

	assign tx_below = {1'b0, tx_l.count} < trig.tx_lvl;
	assign tx_empty = (tx_l.count == 7'h00);

	always_comb begin
		tx_below_nxt = tx_below;
		tx_empty_nxt = tx_empty;
		tx_over_nxt  = tx_over_r;
		// remembers whether the last reload went past the trigger
		if ({1'b0, tx_l.count} > trig.tx_lvl) begin
			tx_over_nxt = 1'b1;
		end else if (tx_empty) begin
			tx_over_nxt = 1'b0;
		end
		tx_set = en_r && ((tx_below && !tx_below_r) || (tx_empty && !tx_empty_r && !tx_over_r));
		tx_int_nxt = tx_int_r;
		if (rd_status || tx_push || !en_r) begin
			tx_int_nxt = 1'b0;
		end
		// a new event beats a clear in the same cycle
		if (tx_set) begin
			tx_int_nxt = 1'b1;
		end
		rx_int_nxt = en_r && ({1'b0, rx_l.count} >= trig.rx_lvl);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_below_r <= 1'b0;
			tx_empty_r <= 1'b1;
			tx_over_r  <= 1'b0;
			tx_int_r   <= 1'b0;
			rx_int_r   <= 1'b0;
		end else begin
			tx_below_r <= tx_below_nxt;
			tx_empty_r <= tx_empty_nxt;
			tx_over_r  <= tx_over_nxt;
			tx_int_r   <= tx_int_nxt;
			rx_int_r   <= rx_int_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// ready pins

	logic rx_pin_n_r;
	logic rx_pin_n_nxt;
	logic tx_pin_n_r;
	logic tx_pin_n_nxt;

	always_comb begin
		if (dma_r && en_r) begin
			// dma: rx asks once the trigger is reached, tx offers while room remains
			rx_pin_n_nxt = !({1'b0, rx_l.count} >= trig.rx_lvl);
			tx_pin_n_nxt = tx_l.full;
		end else begin
			// normal: rx asks while anything is buffered, tx offers only when empty
			rx_pin_n_nxt = (rx_l.count == 7'h00);
			tx_pin_n_nxt = !tx_empty;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_pin_n_r <= 1'b1;
			tx_pin_n_r <= 1'b0;
		end else begin
			rx_pin_n_r <= rx_pin_n_nxt;
			tx_pin_n_r <= tx_pin_n_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data

	logic [7:0] status_byte;
	logic [7:0] shadow_byte;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	// status gives the pending interrupt bits; bit 0 is high while nothing is pending
	assign status_byte = {en_r, en_r, 2'h0, dma_r, rx_int_r, tx_int_r, !(rx_int_r || tx_int_r)};
	// the flush acts on the write edge itself, so no reset bit is ever stored
	// reset bits self clear
	assign shadow_byte = {rxsel_r, txsel_r, dma_r, 2'h0, en_r};

	always_comb begin
		rdata_nxt = 8'h00;
		if (bus_rd) begin
			unique case (bus_addr)
				`UFC_ADDR_CTL:    rdata_nxt = status_byte;
				`UFC_ADDR_FEAT:   rdata_nxt = feat_r;
				`UFC_ADDR_ENH:    rdata_nxt = enh_r;
				`UFC_ADDR_LVL:    rdata_nxt = feat_r[`UFC_FEAT_DIR] ? txprog_r : rxprog_r;
				`UFC_ADDR_RXCNT:  rdata_nxt = {1'b0, rx_l.count};
				`UFC_ADDR_SHADOW: rdata_nxt = shadow_byte;
				default:          rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign rx_count       = rx_l.count;
	assign tx_count       = tx_l.count;
	assign bus_rdata      = rdata_r;
	assign fifo_en        = en_r;
	assign dma_mode       = dma_r;
	assign rx_int         = rx_int_r;
	assign tx_int         = tx_int_r;
	assign rx_ready_pin_n = rx_pin_n_r;
	assign tx_ready_pin_n = tx_pin_n_r;
endmodule : ufc_top

`default_nettype wire

/* verif/ufc_top_properties.sv */
`timescale 1ns/10ps
`default_nettype none

module ufc_top_properties (
	input wire logic       sys_clk,
	input wire logic       srst,
	input wire logic [2:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic       bus_wr,
	input wire logic       bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic       tx_push,
	input wire logic [6:0] rx_count,
	input wire logic [6:0] tx_count,
	input wire logic       fifo_en,
	input wire logic       dma_mode,
	input wire logic       rx_int,
	input wire logic       tx_int,
	input wire logic       rx_ready_pin_n,
	input wire logic       tx_ready_pin_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////
	property p_rx_flush;
		bus_wr && bus_addr == 3'h2 && bus_wdata[0] && bus_wdata[1] |=> rx_count == 7'h00;
	endproperty
	a_rx_flush: assert property (p_rx_flush) else $error("rx flush missed");
	property p_tx_flush;
		bus_wr && bus_addr == 3'h2 && bus_wdata[0] && bus_wdata[2] |=> tx_count == 7'h00;
	endproperty
	a_tx_flush: assert property (p_tx_flush) else $error("tx flush missed");
	property p_rst_bits;
		bus_rd && bus_addr == 3'h7 |=> bus_rdata[2:1] == 2'h0;
	endproperty
	a_rst_bits: assert property (p_rst_bits) else $error("reset bit reads set");
	property p_dma;
		bus_wr && bus_addr == 3'h2 && bus_wdata[0] |=> dma_mode == $past(bus_wdata[3]);
	endproperty
	a_dma: assert property (p_dma) else $error("dma bit not taken");
	property p_no_en;
		bus_wr && bus_addr == 3'h2 && !bus_wdata[0] |=> !fifo_en && $stable(dma_mode);
	endproperty
	a_no_en: assert property (p_no_en) else $error("disabled write took bits");
	property p_rx_int_en;
		!fifo_en ##1 !fifo_en |-> !rx_int;
	endproperty
	a_rx_int_en: assert property (p_rx_int_en) else $error("rx int without fifo");
	property p_tx_clr;
		$fell(tx_int) |-> ($past(bus_rd) && $past(bus_addr) == 3'h2) || $past(tx_push)
			|| !$past(fifo_en);
	endproperty
	a_tx_clr: assert property (p_tx_clr) else $error("tx int dropped alone");
	property p_pins;
		!$past(dma_mode) |-> tx_ready_pin_n == ($past(tx_count) != 7'h00)
			&& rx_ready_pin_n == ($past(rx_count) == 7'h00);
	endproperty
	a_pins: assert property (p_pins) else $error("normal pin level wrong");
	property p_dma_pins;
		$past(dma_mode) && $past(fifo_en) |-> tx_ready_pin_n == ($past(tx_count) == 7'h40)
			&& rx_ready_pin_n == !rx_int;
	endproperty
	a_dma_pins: assert property (p_dma_pins) else $error("dma pin level wrong");
endmodule : ufc_top_properties

bind ufc_top ufc_top_properties u_props (.sys_clk(sys_clk), .srst(srst), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .tx_push(tx_push),
	.rx_count(rx_count), .tx_count(tx_count), .fifo_en(fifo_en), .dma_mode(dma_mode), .rx_int(rx_int),
	.tx_int(tx_int), .rx_ready_pin_n(rx_ready_pin_n), .tx_ready_pin_n(tx_ready_pin_n));

`default_nettype wire

/* verif/ufc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module ufc_host_model (
	input  wire logic       sys_clk,
	input  wire logic [7:0] bus_rdata,
	output var logic  [2:0] bus_addr,
	output var logic  [7:0] bus_wdata,
	output var logic        bus_wr,
	output var logic        bus_rd
);
	initial begin
		bus_addr = 3'h0;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	end
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		bus_wr = 1'b0;
		// idle bus shows inverted junk, not the last value
		bus_addr = ~a;
		bus_wdata = ~d;
	endtask : wr
	task rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		bus_addr = a;
		bus_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		bus_rd = 1'b0;
		bus_addr = ~a;
		d = bus_rdata;
	endtask : rd
endmodule : ufc_host_model

`default_nettype wire

/* verif/tb_uart_fifo_control_trigger.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_uart_fifo_control_trigger;
	logic       sys_clk;
	logic       srst;
	logic [2:0] bus_addr;
	logic [7:0] bus_wdata;
	logic       bus_wr;
	logic       bus_rd;
	logic [7:0] bus_rdata;
	logic [3:0] dp;
	logic [6:0] rx_count;
	logic [6:0] tx_count;
	logic       fifo_en;
	logic       dma_mode;
	logic       rx_int;
	logic       tx_int;
	logic       tx_ready_pin_n;
	logic [7:0] d;
	logic [7:0] rl;
	logic [7:0] tl;
	int         fails;
	int         total_checks;
	logic [7:0] rxe [12] = '{8'h01, 8'h04, 8'h08, 8'h0e, 8'h08, 8'h10, 8'h18, 8'h1c, 8'h08, 8'h10, 8'h38, 8'h3c};
	logic [7:0] txe [12] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h10, 8'h08, 8'h18, 8'h1e, 8'h08, 8'h10, 8'h20, 8'h38};

	ufc_host_model host (.sys_clk(sys_clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd));
	ufc_top dut (.sys_clk(sys_clk), .srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .rx_push(dp[0]), .rx_pop(dp[1]), .tx_push(dp[2]),
		.tx_pop(dp[3]), .rx_count(rx_count), .tx_count(tx_count), .fifo_en(fifo_en), .dma_mode(dma_mode),
		.rx_int(rx_int), .tx_int(tx_int), .rx_ready_pin_n(), .tx_ready_pin_n(tx_ready_pin_n));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////
	task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task stop_test;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	task dp_pulse(input logic [3:0] v);
		@(posedge sys_clk);
		#1;
		dp = v;
		@(posedge sys_clk);
		#1;
		dp = 4'h0;
	endtask : dp_pulse
	// flushes both sides, then finds the rx and tx trigger levels from the interrupts
	task measure(input logic [7:0] f, output logic [7:0] r, output logic [7:0] t);
		r = 8'hff;
		t = 8'hff;
		host.wr(3'h2, f | 8'h06);
		for (int i = 0; i < 64 && r === 8'hff; i++) begin
			dp_pulse(4'h1);
			@(posedge sys_clk);
			#1;
			if (rx_int === 1'b1) begin
				r = {1'b0, rx_count};
			end
		end
		repeat (64) dp_pulse(4'h4);
		host.rd(3'h2, d);
		for (int i = 0; i < 64 && t === 8'hff; i++) begin
			dp_pulse(4'h8);
			@(posedge sys_clk);
			#1;
			if (tx_int === 1'b1) begin
				t = {1'b0, tx_count} + 8'h01;
			end
		end
	endtask : measure
	////////////////////////////////////////////////////////////
	initial begin
		dp = 4'h0;
		srst = 1'b1;
		fails = 0;
		total_checks = 0;
		repeat (6) @(posedge sys_clk);
		#1;
		srst = 1'b0;
		host.rd(3'h2, d);
		check("status", d, 8'h01);
		host.rd(3'h7, d);
		check("shadow", d, 8'h00);
		host.wr(3'h1, 8'hff);
		host.rd(3'h1, d);
		check("unmapped", d, 8'h00);
		measure(8'h01, rl, tl);
		check("rx default", rl, 8'h01);
		check("tx default", tl, 8'h01);
		dp_pulse(4'h5);
		dp_pulse(4'h5);
		host.wr(3'h2, 8'h03);
		check("rx flushed", {1'b0, rx_count}, 8'h00);
		check("tx kept", {1'b0, tx_count}, 8'h02);
		host.wr(3'h2, 8'h04);
		check("en cleared", {7'h00, fifo_en}, 8'h00);
		check("tx not flushed", {1'b0, tx_count}, 8'h02);
		host.wr(3'h2, 8'h05);
		check("tx flushed", {1'b0, tx_count}, 8'h00);
		host.wr(3'h2, 8'h09);
		check("dma on", {7'h00, dma_mode}, 8'h01);
		host.rd(3'h7, d);
		check("shadow dma", d, 8'h09);
		host.wr(3'h2, 8'h01);
		check("dma off", {7'h00, dma_mode}, 8'h00);
		host.wr(3'h2, 8'h31);
		host.rd(3'h7, d);
		check("tx sel locked", d, 8'h01);
		host.wr(3'h4, 8'h10);
		host.wr(3'h2, 8'h31);
		host.rd(3'h7, d);
		check("tx sel open", d, 8'h31);
		for (int t = 0; t < 3; t++) begin
			for (int c = 0; c < 4; c++) begin
				host.wr(3'h3, {2'h0, t[1:0], 4'h0});
				measure({c[1:0], c[1:0], 4'h1}, rl, tl);
				check("rx level", rl, rxe[t * 4 + c]);
				check("tx level", tl, txe[t * 4 + c]);
			end
		end
		host.wr(3'h3, 8'h30);
		host.wr(3'h5, 8'h05);
		host.wr(3'h3, 8'hb0);
		host.wr(3'h5, 8'h07);
		host.rd(3'h5, d);
		check("tx prog", d, 8'h07);
		measure(8'hf9, rl, tl);
		check("rx prog level", rl, 8'h05);
		check("tx prog level", tl, 8'h07);
		check("tx pin dma", {7'h00, tx_ready_pin_n}, 8'h00);
		stop_test();
	end
endmodule : tb_uart_fifo_control_trigger

`default_nettype wire
